// ### core/long_addr_move_or_rotl_exec.v
// Execution datapath for extended-address move, OR and rotate-left instructions
`timescale 1ns/1ps
`default_nettype none
`include "long_exec_defs.vh"

module long_addr_move_or_rotl_exec
(
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Decoded instruction from the sequencer
	input wire exec_valid,
	input wire [3:0] opcode,
	input wire [7:0] mem_rdata,
	// Accumulator and flags
	output reg [7:0] acc_reg,
	output reg zero_flag_reg,
	output reg carry_flag_reg,
	// Memory write-back and completion
	output reg mem_we_reg,
	output reg [7:0] mem_wdata_reg,
	output reg done_reg
);

	// ----------------------------------------
	// Rotate units
	// ----------------------------------------
	wire [7:0] rot_plain;
	wire [7:0] rot_carry;
	wire rot_carry_msb;

	// Plain rotate feeds the old top bit back into bit 0
	rotl_unit u_rot_plain
	(
		.operand(mem_rdata),
		.fill_bit(mem_rdata[7]),
		.result(rot_plain),
		.out_bit()
	);

	// Carry rotate fills bit 0 from the flag as it stands, so a
	// back-to-back pair sees the carry left by the first one
	rotl_unit u_rot_carry
	(
		.operand(mem_rdata),
		.fill_bit(carry_flag_reg),
		.result(rot_carry),
		.out_bit(rot_carry_msb)
	);

	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	// Only listed opcodes complete; anything else is dropped silently so
	// a stray code from the sequencer cannot disturb acc or the flags
	reg known_op;

	always @*
	begin
		case (opcode)
			`OP_LONG_MOVE_TO_ACC,
			`OP_LONG_MOVE_TO_MEM,
			`OP_LONG_OR_TO_ACC,
			`OP_LONG_OR_TO_MEM,
			`OP_LONG_ROTATE_LEFT,
			`OP_LONG_ROTATE_LEFT_TO_ACC,
			`OP_LONG_ROTATE_LEFT_CARRY,
			`OP_LONG_ROTATE_LEFT_CARRY_TO_ACC:
			begin
				known_op = 1'b1;
			end
			default:
			begin
				known_op = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Operand combine and zero detect
	// ----------------------------------------
	// Zero is judged on the full 8-bit result, never on a single operand
	wire [7:0] or_result;
	wire or_is_zero;

	assign or_result = acc_reg | mem_rdata;
	assign or_is_zero = (or_result == 8'h00);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	reg [7:0] acc_next;
	reg zero_flag_next;
	reg carry_flag_next;
	reg mem_we_next;
	reg [7:0] mem_wdata_next;
	reg done_next;

	always @*
	begin
		acc_next = acc_reg;
		zero_flag_next = zero_flag_reg;
		carry_flag_next = carry_flag_reg;
		mem_we_next = 1'b0;
		mem_wdata_next = mem_wdata_reg;
		done_next = 1'b0;
		if (exec_valid)
		begin
			done_next = known_op;
			case (opcode)
				`OP_LONG_MOVE_TO_ACC:
				begin
					acc_next = mem_rdata;
				end
				`OP_LONG_MOVE_TO_MEM:
				begin
					mem_we_next = 1'b1;
					mem_wdata_next = acc_reg;
				end
				`OP_LONG_OR_TO_ACC:
				begin
					acc_next = or_result;
					zero_flag_next = or_is_zero;
				end
				`OP_LONG_OR_TO_MEM:
				begin
					mem_we_next = 1'b1;
					mem_wdata_next = or_result;
					zero_flag_next = or_is_zero;
				end
				`OP_LONG_ROTATE_LEFT:
				begin
					mem_we_next = 1'b1;
					mem_wdata_next = rot_plain;
				end
				`OP_LONG_ROTATE_LEFT_TO_ACC:
				begin
					acc_next = rot_plain;
				end
				`OP_LONG_ROTATE_LEFT_CARRY:
				begin
					mem_we_next = 1'b1;
					mem_wdata_next = rot_carry;
					carry_flag_next = rot_carry_msb;
				end
				`OP_LONG_ROTATE_LEFT_CARRY_TO_ACC:
				begin
					acc_next = rot_carry;
					carry_flag_next = rot_carry_msb;
				end
				default:
				begin
					// Unknown opcode: no state change, no completion
					done_next = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Accumulator
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			acc_reg <= `ACC_RESET;
		end
		else
		begin
			acc_reg <= acc_next;
		end
	end

	// Status flags; each keeps its value unless its own opcodes touch it
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			zero_flag_reg <= `FLAG_RESET;
			carry_flag_reg <= `FLAG_RESET;
		end
		else
		begin
			zero_flag_reg <= zero_flag_next;
			carry_flag_reg <= carry_flag_next;
		end
	end

	// Memory write-back; the strobe is a single-cycle pulse per write
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			mem_we_reg <= 1'b0;
			mem_wdata_reg <= `WDATA_RESET;
		end
		else
		begin
			mem_we_reg <= mem_we_next;
			mem_wdata_reg <= mem_wdata_next;
		end
	end

	// Completion pulse back to the sequencer
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= done_next;
		end
	end

endmodule // long_addr_move_or_rotl_exec

`default_nettype wire

// ### core/long_exec_defs.vh
// Opcode encodings and widths for the extended-address move, OR and rotate-left group
`ifndef LONG_EXEC_DEFS_VH
`define LONG_EXEC_DEFS_VH

`define DATA_W 8
`define OP_W 4

`define OP_NONE 4'h0
`define OP_LONG_MOVE_TO_ACC 4'h1
`define OP_LONG_MOVE_TO_MEM 4'h2
`define OP_LONG_OR_TO_ACC 4'h3
`define OP_LONG_OR_TO_MEM 4'h4
`define OP_LONG_ROTATE_LEFT 4'h5
`define OP_LONG_ROTATE_LEFT_TO_ACC 4'h6
`define OP_LONG_ROTATE_LEFT_CARRY 4'h7
`define OP_LONG_ROTATE_LEFT_CARRY_TO_ACC 4'h8

`define ACC_RESET 8'h00
`define FLAG_RESET 1'h0
`define WDATA_RESET 8'h00

`endif

// ### core/rotl_unit.v
// Single-bit left rotate, with selectable fill bit for the lowest position
`timescale 1ns/1ps
`default_nettype none
`include "long_exec_defs.vh"

module rotl_unit
(
	// Operand
	input wire [7:0] operand,
	input wire fill_bit,
	// Result
	output wire [7:0] result,
	output wire out_bit
);

	assign result = {operand[6:0], fill_bit};
	assign out_bit = operand[7];

endmodule // rotl_unit

`default_nettype wire

// ### testbench/long_exec_sva.sv
// Assertions for the long move, OR and rotate datapath
`timescale 1ns/1ps
`default_nettype none
module long_exec_sva(input wire logic sys_clk,rst,exec_valid,zero_flag_reg,carry_flag_reg,
	mem_we_reg,done_reg,input wire logic [3:0] opcode,
	input wire logic [7:0] mem_rdata,acc_reg,mem_wdata_reg);
// Operands as seen at the taking edge
logic v;
logic [3:0] o;
logic [7:0] m,a;
logic [1:0] f;
wire [1:0] fl={zero_flag_reg,carry_flag_reg};
wire [7:0] ac=acc_reg;
wire [7:0] wd=mem_wdata_reg;
wire w=mem_we_reg;
always @(posedge sys_clk)
begin
	v<=exec_valid&!rst;
	o<=opcode;
	m<=mem_rdata;
	a<=acc_reg;
	f<=fl;
end
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
a_move_acc: assert property(v&&o==1 |-> !w&&ac==m&&fl==f) else $error("fail");
a_move_mem: assert property(v&&o==2 |-> w&&wd==a&&fl==f) else $error("fail");
a_or_acc: assert property(v&&o==3 |-> !w&&ac==(a|m)&&fl=={(a|m)==0,f[0]})
	else $error("fail");
a_or_mem: assert property(v&&o==4 |-> w&&wd==(a|m)&&fl=={(a|m)==0,f[0]})
	else $error("fail");
a_rotl_mem: assert property(v&&o==5 |-> w&&wd=={m[6:0],m[7]}&&fl==f)
	else $error("fail");
a_rotl_acc: assert property(v&&o==6 |-> !w&&ac=={m[6:0],m[7]}&&fl==f)
	else $error("fail");
a_rotc_mem: assert property(v&&o==7 |-> w&&{fl[0],wd}=={m,f[0]}) else $error("fail");
a_rotc_acc: assert property(v&&o==8 |-> !w&&{fl[0],ac}=={m,f[0]}) else $error("fail");
a_done_known: assert property(v&&o>0&&o<9 |-> done_reg)
	else $error("fail");
a_refused_idle: assert property(v&&(o==0||o>8) |-> !done_reg&&!w&&ac==a&&fl==f)
	else $error("fail");
endmodule // long_exec_sva
bind long_addr_move_or_rotl_exec long_exec_sva chk_u(.*);
`default_nettype wire

// ### testbench/mem_model.sv
// Single memory byte feeding the datapath operand
`timescale 1ns/1ps
`default_nettype none
module mem_model(input wire logic sys_clk,mem_we_reg,ld,
	input wire logic [7:0] mem_wdata_reg,ld_d,output wire logic [7:0] mem_rdata);
// Preload wins so the bench can set an operand between instructions
logic [7:0] byte_q;
always @(posedge sys_clk)
	if (ld) byte_q<=ld_d;
	else if (mem_we_reg) byte_q<=mem_wdata_reg;
// Write-through: the next instruction may read this byte on the very next edge
assign mem_rdata=(mem_we_reg&&!ld)?mem_wdata_reg:byte_q;
endmodule // mem_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the long move, OR and rotate datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin n_compared++; if ((a)!==(e)) begin n_fail++; \
	$display("ERROR %0t %h %h",$time,a,e); end end
module testbench;
logic sys_clk=0,rst=1,exec_valid=0,ld=0,mem_we_reg,zero_flag_reg,carry_flag_reg,done_reg;
logic [3:0] opcode=0;
logic [7:0] ld_d=0,mem_rdata,acc_reg,mem_wdata_reg;
int n_fail=0,n_compared=0,cyc=0;
// Rows: opcode, operand, acc, memory byte, carry, zero
logic [31:0] r,t[12]='{32'h18181810,32'h78181022,32'h84081400,32'h58081010,
	32'h6C387C30,32'h10000000,32'h30000001,32'h41000100,32'h40000001,
	32'h1A5A5A51,32'h23CA5A51,32'h0FFA5FF1};
mem_model pm_u(.*);
long_addr_move_or_rotl_exec dut_u(.*);
initial forever #50 sys_clk=~sys_clk;
task close_out;
	$display("fails %0d compares %0d",n_fail,n_compared);
	if (n_fail==0&&n_compared>0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
always @(posedge sys_clk)
	if (++cyc==300)
	begin
		n_fail++;
		close_out;
	end
initial
begin
	repeat (6) @(posedge sys_clk);
	rst<=0;
	@(posedge sys_clk) #1 `CHK({acc_reg,zero_flag_reg,carry_flag_reg,mem_we_reg,done_reg},12'h0)
	foreach (t[i])
	begin
		r=t[i];
		@(posedge sys_clk) ld<=1;
		ld_d<=r[27:20];
		@(posedge sys_clk) ld<=0;
		exec_valid<=1;
		opcode<=r[31:28];
		@(posedge sys_clk) exec_valid<=0;
		#1 `CHK(done_reg,r[31:28]!=0)
		@(posedge sys_clk) #1 `CHK({acc_reg,mem_rdata,2'b0,carry_flag_reg,zero_flag_reg},r[19:0])
	end
	// Back to back carry rotates: the second must see the first's carry
	@(posedge sys_clk) ld<=1;
	ld_d<=8'h81;
	@(posedge sys_clk) ld<=0;
	exec_valid<=1;
	opcode<=4'h7;
	@(posedge sys_clk);
	@(posedge sys_clk) exec_valid<=0;
	@(posedge sys_clk) #1 `CHK({carry_flag_reg,mem_rdata},9'h005)
	close_out;
end
endmodule // testbench
`default_nettype wire
